// ---- hw/bpr_arbiter.sv ----
// ----------------------------------------------------------------
// Functional notes
// ----------------------------------------------------------------
// Functional notes
// - Wanting the bus drives priority out high, blocking lower masters.
// - Finished with the bus, drive priority out low only while priority in is active.
// - Not wanting the bus with priority in active, drive priority out low.
// - In parallel mode the priority output is disabled entirely.
// - A waiting master not owning the bus asserts shared request.
`timescale 1ns/100ps

module bpr_arbiter
  import bpr_pkg::*;
#(
  parameter int SYNC_DEPTH = 3
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         clk_en,
  input  wire logic         parallel_mode,
  input  wire logic         bus_req,
  input  wire logic         bus_done,
  input  wire logic         bus_priority_in_n,
  output bpr_bus_out_t      bus_pins,
  output logic              bus_priority_out_oe,
  output logic              shared_request_n_o,
  output logic              shared_request_n_oe,
  output logic              bus_grant
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Fewer than three stages leaves no settled pair of stages to compare
  if (SYNC_DEPTH < 3) begin : g_bad_sync_depth
    $error("bpr_arbiter: SYNC_DEPTH must be at least 3");
  end

  // ----------------------------------------------------------------
  // State decoding helpers
  // ----------------------------------------------------------------
  function automatic logic state_waits(input bpr_state_t s);
    return (s == BPR_WAIT);
  endfunction

  function automatic logic state_owns(input bpr_state_t s);
    return (s == BPR_OWN);
  endfunction

  function automatic logic state_wants(input bpr_state_t s);
    return (s != BPR_IDLE);
  endfunction

  // Without a live priority input we keep blocking, so a busy higher
  // master stays shielded from every master further down the chain
  function automatic logic chain_blocks(input logic wants, input logic prio_ok);
    return wants || !prio_ok;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser: change counts once the last two stages agree
  // ----------------------------------------------------------------
  logic [SYNC_DEPTH-1:0] prio_sync_reg;
  logic                  prio_in_reg;
  logic                  sync_settled;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prio_sync_reg <= {SYNC_DEPTH{BPR_PIN_IDLE}};
    end else if (clk_en) begin
      prio_sync_reg <= {prio_sync_reg[SYNC_DEPTH-2:0], bus_priority_in_n};
    end
  end

  // Adds no latency to a steady change but rejects a single-cycle glitch
  assign sync_settled = (prio_sync_reg[SYNC_DEPTH-1] == prio_sync_reg[SYNC_DEPTH-2]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prio_in_reg <= BPR_PRIO_IN_RST;
    end else if (clk_en && sync_settled) begin
      prio_in_reg <= ~prio_sync_reg[SYNC_DEPTH-1];
    end
  end

  // ----------------------------------------------------------------
  // Ownership state
  // ----------------------------------------------------------------
  bpr_state_t state_reg;
  bpr_state_t state_next;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BPR_IDLE: begin
        if (bus_req) begin
          state_next = BPR_WAIT;
        end
      end
      BPR_WAIT: begin
        if (!bus_req) begin
          state_next = BPR_IDLE;
        end else if (prio_in_reg) begin
          state_next = BPR_OWN;
        end
      end
      BPR_OWN: begin
        if (bus_done || !bus_req || !prio_in_reg) begin
          state_next = BPR_IDLE;
        end
      end
      default: state_next = BPR_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= BPR_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------------
  logic wants_next;
  logic waits_next;
  logic owns_next;
  logic block_next;

  assign wants_next = state_wants(state_next);
  assign waits_next = state_waits(state_next);
  assign owns_next  = state_owns(state_next);
  assign block_next = chain_blocks(wants_next, prio_in_reg);

  // One process owns the whole pin struct, so every field has one driver
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_pins.prio_out_n <= BPR_PRIO_OUT_RST;
      bus_pins.req_o      <= BPR_REQ_LEVEL;
      bus_pins.req_oe     <= BPR_OE_RST;
    end else if (clk_en) begin
      bus_pins.prio_out_n <= block_next;
      bus_pins.req_o      <= BPR_REQ_LEVEL;
      bus_pins.req_oe     <= waits_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_priority_out_oe <= BPR_OE_RST;
    end else if (clk_en) begin
      bus_priority_out_oe <= ~parallel_mode;
    end
  end

  // ----------------------------------------------------------------
  // Shared request
  // ----------------------------------------------------------------
  // Open drain: drive low only, release otherwise; dropped while owning
  // so the line only tells the owner that someone else is waiting
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shared_request_n_o  <= BPR_REQ_LEVEL;
      shared_request_n_oe <= BPR_OE_RST;
    end else if (clk_en) begin
      shared_request_n_o  <= BPR_REQ_LEVEL;
      shared_request_n_oe <= waits_next;
    end
  end

  // ----------------------------------------------------------------
  // Grant
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_grant <= BPR_GRANT_RST;
    end else if (clk_en) begin
      bus_grant <= owns_next;
    end
  end

endmodule

// ---- hw/bpr_pkg.sv ----
package bpr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;

  // ----------------------------------------------------------------
  // Arbiter states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BPR_IDLE  = 2'b00,
    BPR_WAIT  = 2'b01,
    BPR_OWN   = 2'b10
  } bpr_state_t;

  // ----------------------------------------------------------------
  // Bus-side pin group (active-low lines, open-collector style)
  // ----------------------------------------------------------------
  typedef struct packed {
    logic prio_out_n;
    logic req_o;
    logic req_oe;
  } bpr_bus_out_t;

  localparam logic BPR_PRIO_OUT_RST = 1'b0;

  // ----------------------------------------------------------------
  // Reset and idle levels
  // ----------------------------------------------------------------
  localparam logic BPR_PIN_IDLE     = 1'b1;
  localparam logic BPR_PRIO_IN_RST  = 1'b0;
  localparam logic BPR_OE_RST       = 1'b0;
  localparam logic BPR_GRANT_RST    = 1'b0;
  localparam logic BPR_REQ_LEVEL    = 1'b0;

endpackage

// ---- bench/bpr_arbiter_chk.sv ----
`timescale 1ns/100ps
module bpr_arbiter_chk
  import bpr_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst,
  input wire logic         parallel_mode,
  input wire logic         bus_req,
  input wire logic         bus_done,
  input wire logic         bus_priority_in_n,
  input wire bpr_bus_out_t bus_pins,
  input wire logic         bus_priority_out_oe,
  input wire logic         shared_request_n_oe,
  input wire logic         bus_grant
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_par_oe_off:
    assert property (parallel_mode [*2] |-> !bus_priority_out_oe) else $error("oe in parallel");
  chk_own_blocks:
    assert property (bus_grant && !parallel_mode |-> bus_pins.prio_out_n) else $error("owner passes");
  chk_idle_pass:
    assert property ((!bus_req && !bus_priority_in_n) [*6] |-> !bus_pins.prio_out_n)
    else $error("idle blocks");
  chk_chain_held:
    assert property (bus_priority_in_n [*6] |-> bus_pins.prio_out_n) else $error("chain not held");
  chk_wait_req:
    assert property ((bus_req && !bus_done && !bus_grant) [*2] |-> shared_request_n_oe)
    else $error("no request");
  chk_own_quiet:
    assert property (bus_grant |-> !shared_request_n_oe) else $error("owner requests");
  chk_no_prio:
    assert property (bus_priority_in_n [*6] |-> !bus_grant) else $error("grant no prio");
  cover property ($rose(bus_grant));
  cover property (bus_priority_in_n && shared_request_n_oe);
  cover property (parallel_mode && bus_grant);
endmodule

bind bpr_arbiter bpr_arbiter_chk chk (.clk, .rst, .parallel_mode, .bus_req, .bus_done,
  .bus_priority_in_n, .bus_pins, .bus_priority_out_oe, .shared_request_n_oe, .bus_grant);

// ---- bench/bpr_peer.sv ----
`timescale 1ns/100ps
module bpr_peer (
  input  wire logic       clk,
  input  wire logic       par,
  input  wire logic       want,
  input  wire logic [7:0] breq,
  output logic            prio_n
);
  logic [2:0] top;
  // encoder takes highest request, line 7 first
  always_comb begin
    top = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (breq[i]) begin
        top = i[2:0];
      end
    end
  end
  // serial head, priority in tied active, blocks after wanting
  // decoder frees only line 3 (ours); line 7 lacks shared request
  always_ff @(posedge clk) prio_n <= par ? (top != 3'h3) : want;
endmodule

// ---- bench/tb_bus_priority_resolution.sv ----
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_bus_priority_resolution;
  import bpr_pkg::*;
  logic         clk = 0, rst = 1, par = 0, req = 0, done = 0, want = 0;
  logic         prio_n, po_oe, sr_oe, sr_o, grant, timed_out = 0;
  bpr_bus_out_t pins;
  int           n_fail = 0, num_checks = 0, k;
  logic [31:0]  rs = 32'h232323c1;
  always #12.5 clk = ~clk;
  bpr_peer peer (.clk(clk), .par(par), .want(want), .breq({want, 3'h0, req, 3'h0}),
    .prio_n(prio_n));
  bpr_arbiter dut (.clk(clk), .rst(rst), .clk_en(1'b1), .parallel_mode(par), .bus_req(req),
    .bus_done(done), .bus_priority_in_n(prio_n), .bus_pins(pins), .bus_priority_out_oe(po_oe),
    .shared_request_n_o(sr_o), .shared_request_n_oe(sr_oe), .bus_grant(grant));
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // Once idle, the chain stays blocked while a higher master is busy
  function automatic logic exp_prio_out(logic busy);
    return busy;
  endfunction
  task end_of_test;
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // A busy higher master must hold us off and keep our shared request up
  task run(logic w, logic p);
    @(posedge clk) {want, par, req, done} <= {w, p, 2'b00};
    repeat (6) @(posedge clk);
    req <= 1'b1;
    k = 0;
    if (w) begin
      repeat (12) @(negedge clk);
    end else begin
      do @(negedge clk); while (grant !== 1'b1 && ++k < 12);
    end
    if (k == 12) begin
      `CHK("grant wait", 1'b1, grant)
      timed_out = 1'b1;
      return;
    end
    `CHK("grant", !w, grant)
    `CHK("shared request", w, sr_oe)
    `CHK("request drive", {w, 2'b00}, {pins.req_oe, pins.req_o, sr_o})
    `CHK("prio out oe", !p, po_oe)
    @(posedge clk) {req, done} <= 2'b01;
    @(posedge clk) done <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK("prio out", exp_prio_out(w), pins.prio_out_n)
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (!timed_out) run(i[0], i[1]);
    end
    if (!timed_out) begin
      repeat (400) begin
        @(posedge clk);
        rs = xs(rs);
        {par, want, req, done} <= {1'b0, rs[7:6] == 2'b11, rs[9:8] != 2'b00,
          rs[12:10] == 3'b000};
      end
    end
    end_of_test();
  end
endmodule
